//--- sim/analog_comparator_control_monitor.sv
// assertion checker for the comparator control block
`timescale 1ns/100ps
module analog_comparator_control_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  input wire comparator_pkg::analog_ctl_t analog_ctl_o,
  input wire logic port_a_pin_zero_o,
  input wire logic timer_clock_source_o,
  input wire logic wake_o,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // bus answer and read data holding
  a_wait_one_cycle: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("waitrequest held past one cycle");
  a_read_data_hold: assert property (!(read_i && waitrequest_o) |=> $stable(readdata_o))
    else $error("read data changed without a read");
  // analog switch decoding
  a_off_all_open: assert property (!analog_ctl_o.enable |-> analog_ctl_o[12:6] == 7'h00)
    else $error("switch closed while comparator disabled");
  a_plus_one_hot: assert property (analog_ctl_o.enable |-> analog_ctl_o.plus_ladder != analog_ctl_o.plus_pin_four)
    else $error("plus input not exactly one source");
  a_minus_at_most: assert property ($onehot0(analog_ctl_o[10:6]))
    else $error("more than one minus source");
  // result consumers
  a_timer_source: assert property (timer_clock_source_o == port_a_pin_zero_o)
    else $error("timer source differs from pin result");
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  a_wake_cause: assert property (wake_o |-> $past(port_a_pin_zero_o) != $past(port_a_pin_zero_o, 2)
    && $past(analog_ctl_o.enable))
    else $error("wake without a result change");

  c_read_done: cover property (read_i && !waitrequest_o);
  c_wake_seen: cover property (wake_o);
  c_irq_rise: cover property ($rose(irq_o));
endmodule : analog_comparator_control_monitor

bind analog_comparator_control analog_comparator_control_monitor i_monitor (.sys_clk_i, .rst_i, .read_i,
  .write_i, .readdata_o, .waitrequest_o, .analog_ctl_o, .port_a_pin_zero_o, .timer_clock_source_o,
  .wake_o, .irq_o);

//--- sim/analog_comparator_control_tb_top.sv
// self-checking testbench for the comparator control block
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp); \
    end \
  end

module analog_comparator_control_tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] address_i = 8'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [3:0] byteenable_i = 4'hF;
  logic [31:0] writedata_i = 32'h0;
  logic compare_raw_i = 1'b0;
  logic timer_two_clock_i = 1'b0;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  comparator_pkg::analog_ctl_t analog_ctl_o;
  logic port_a_pin_zero_o;
  logic port_a_pin_zero_oe_o;
  logic timer_clock_source_o;
  logic wake_o;
  logic irq_o;
  logic [31:0] rdata;
  int mismatches = 0;
  int n_compared = 0;

  analog_comparator_control i_dut (.sys_clk_i, .rst_i, .address_i, .read_i, .write_i, .byteenable_i,
    .writedata_i, .readdata_o, .waitrequest_o, .compare_raw_i, .timer_two_clock_i, .analog_ctl_o,
    .port_a_pin_zero_o, .port_a_pin_zero_oe_o, .timer_clock_source_o, .wake_o, .irq_o);

  // 40 MHz clock
  initial
  begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // one avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic is_write, input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] be);
    int i;
    @(posedge sys_clk_i);
    address_i <= adr;
    write_i <= is_write;
    read_i <= !is_write;
    writedata_i <= {24'h0, dat};
    byteenable_i <= be;
    // values read here are those sampled by this rising edge
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk_i);
      if (!waitrequest_o)
        break;
    end
    if (i == 20)
    begin
      mismatches++;
      stop_test();
    end
    rdata = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] adr);
    bus(1'b0, adr, 8'h00, 4'hF);
  endtask : rd

  // one timer-two clock pulse, then settle
  task automatic tick;
    timer_two_clock_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    timer_two_clock_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
  endtask : tick

  task automatic t_reset;
    `CHK(analog_ctl_o, 14'h0000)
    `CHK(port_a_pin_zero_oe_o, 1'b0)
    rd(8'h60);
    `CHK(rdata, 32'h0)
    wr(8'h61, 8'h9F);
    rd(8'h60);
    `CHK(rdata, 32'h0)
    wr(8'h60, 8'h40);
    rd(8'h60);
    `CHK(rdata, 32'h0)
    wr(8'h70, 8'hFF);
    rd(8'h70);
    `CHK(rdata, 32'h0)
  endtask : t_reset

  task automatic t_inputs;
    comparator_pkg::analog_ctl_t exp;
    for (int c = 0; c < 16; c++)
    begin
      exp = '0;
      exp.enable = 1'b1;
      exp.plus_ladder = !c[0];
      exp.plus_pin_four = c[0];
      exp.minus_pin_three = c[3:1] == 3'h0;
      exp.minus_pin_four = c[3:1] == 3'h1;
      exp.minus_bandgap = c[3:1] == 3'h2;
      exp.minus_ladder = c[3:1] == 3'h3;
      exp.minus_pin_seven = c[3:1] == 3'h5;
      wr(8'h60, 8'(8'h80 | c));
      rd(8'h60);
      `CHK(rdata, 32'h80 | c)
      `CHK(analog_ctl_o, exp)
    end
    wr(8'h60, 8'h0E);
    rd(8'h60);
    `CHK(analog_ctl_o, 14'h0000)
  endtask : t_inputs

  task automatic t_select;
    wr(8'h64, 8'hB5);
    rd(8'h64);
    `CHK(rdata, 32'h0)
    `CHK(port_a_pin_zero_oe_o, 1'b1)
    `CHK(analog_ctl_o[5:0], 6'h35)
    wr(8'h64, 8'h4A);
    bus(1'b1, 8'h64, 8'h0F, 4'h0);
    rd(8'h64);
    `CHK(port_a_pin_zero_oe_o, 1'b0)
    `CHK(analog_ctl_o[5:0], 6'h0A)
    wr(8'h64, 8'h00);
  endtask : t_select

  task automatic t_result;
    wr(8'h6C, 8'h03);
    rd(8'h6C);
    `CHK(rdata, 32'h3)
    wr(8'h60, 8'h80);
    compare_raw_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    rd(8'h60);
    `CHK(rdata, 32'hC0)
    `CHK(port_a_pin_zero_o, 1'b1)
    `CHK(irq_o, 1'b1)
    `CHK(timer_clock_source_o, 1'b1)
    rd(8'h68);
    `CHK(rdata, 32'h1)
    wr(8'h68, 8'h01);
    wr(8'h60, 8'h90);
    repeat (4) @(posedge sys_clk_i);
    `CHK(port_a_pin_zero_o, 1'b0)
    rd(8'h68);
    `CHK(rdata, 32'h2)
    rd(8'h60);
    `CHK(rdata, 32'hD0)
    wr(8'h68, 8'h03);
    wr(8'h6C, 8'h00);
    compare_raw_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    `CHK(port_a_pin_zero_o, 1'b1)
    `CHK(irq_o, 1'b0)
    rd(8'h68);
    `CHK(rdata, 32'h1)
    wr(8'h68, 8'h01);
    rd(8'h68);
    `CHK(rdata, 32'h0)
  endtask : t_result

  task automatic t_resample;
    wr(8'h60, 8'hA0);
    tick();
    `CHK(port_a_pin_zero_o, 1'b0)
    compare_raw_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    `CHK(port_a_pin_zero_o, 1'b0)
    tick();
    `CHK(port_a_pin_zero_o, 1'b1)
    wr(8'h60, 8'h80);
  endtask : t_resample

  // minus code 000 kept, never the bandgap
  task automatic t_wake;
    logic [3:0] n;
    for (int en = 0; en < 2; en++)
    begin
      wr(8'h64, en[0] ? 8'h40 : 8'h00);
      n = 4'h0;
      compare_raw_i <= !compare_raw_i;
      // a four-state count lets an unknown wake show up as a mismatch
      repeat (12)
      begin
        @(negedge sys_clk_i);
        n = n + {3'h0, wake_o};
      end
      `CHK(n, 4'(en))
    end
  endtask : t_wake

  // reset, then each scenario in turn
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_inputs();
    t_select();
    t_result();
    t_resample();
    t_wake();
    stop_test();
  end
endmodule : analog_comparator_control_tb_top

//--- verilog/analog_comparator_control.sv
// register file and result routing around the analog comparator
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps

// Notes on behaviour
// R1 - control bit 0 picks ladder (0) or pin A4 (1) for plus input
// R2 - control bits 3..1 pick minus input; codes 100 and 11X select nothing
// R3 - control bit 7 enables the comparator, reset 0
// R4 - control bit 6 reads 1 when plus exceeds minus, read-only
// R5 - control bit 5 resamples the result on timer-two clock, else direct
// R6 - control bit 4 inverts the result output
// R7 - selection bit 7 drives the result onto port A pin zero
// R8 - selection bit 6 enables wake-up on a result level change
// R9 - selection bits 5 and 4 pick ladder high and low range
// R10 - selection bits 3..0 pick one of sixteen ladder levels
// R11 - software avoids wake-up while the bandgap is the minus input
// R12 - result changes can raise an interrupt request
// R13 - result is offered as a timer clock source
// R14 - resampling on timer-two rising edge; inversion before pin, irq, wake
module analog_comparator_control (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // analog side
  input wire logic compare_raw_i,
  input wire logic timer_two_clock_i,
  output comparator_pkg::analog_ctl_t analog_ctl_o,
  // result consumers
  output logic port_a_pin_zero_o,
  output logic port_a_pin_zero_oe_o,
  output logic timer_clock_source_o,
  output logic wake_o,
  output logic irq_o
);

  // register storage
  logic [7:0] control_reg;
  logic [7:0] selection_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;

  // bus handshake
  comparator_pkg::bus_state_t bus_state_reg;
  comparator_pkg::bus_state_t bus_state_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic request;
  logic accept;
  logic write_take;
  logic word_aligned;
  logic [5:0] reg_index;
  logic lane0;

  // synchronisers
  logic raw_meta_reg;
  logic raw_sync_reg;
  logic tm2_meta_reg;
  logic tm2_sync_reg;
  logic tm2_prev_reg;
  logic tm2_rise;

  // result path
  logic live_result;
  logic shaped_result;
  logic shaped_prev_reg;
  logic result_rise;
  logic result_fall;
  logic [1:0] irq_events;
  logic [1:0] irq_clear;
  logic wake_reg;

  // control field views
  logic comp_enabled;
  logic invert_sel;
  logic resample_sel;
  logic pin_out_sel;
  logic wake_sel;

  assign comp_enabled = control_reg[comparator_pkg::CTL_ENABLE_BIT];
  assign invert_sel = control_reg[comparator_pkg::CTL_INVERT_BIT];
  assign resample_sel = control_reg[comparator_pkg::CTL_RESAMPLE_BIT];
  assign pin_out_sel = selection_reg[comparator_pkg::SEL_PIN_OUT_BIT];
  assign wake_sel = selection_reg[comparator_pkg::SEL_WAKE_BIT];

  // bus decode
  assign request = read_i | write_i;
  assign word_aligned = (address_i[1:0] == 2'h0);
  assign reg_index = address_i[7:2];
  assign lane0 = byteenable_i[0];

  // answer one cycle after the request is seen
  assign accept = request && (bus_state_reg == comparator_pkg::BUS_IDLE);
  assign waitrequest_o = request && (bus_state_reg != comparator_pkg::BUS_ANSWER);
  assign write_take = write_i && (bus_state_reg == comparator_pkg::BUS_ANSWER) && word_aligned && lane0;

  // bus state sequencing
  always_comb
  begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      comparator_pkg::BUS_IDLE:
      begin
        if (request)
          bus_state_next = comparator_pkg::BUS_ANSWER;
      end
      comparator_pkg::BUS_ANSWER:
      begin
        bus_state_next = comparator_pkg::BUS_IDLE;
      end
      default:
      begin
        bus_state_next = comparator_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      bus_state_reg <= comparator_pkg::BUS_IDLE;
    else
      bus_state_reg <= bus_state_next;
  end

  // read mux; unmapped and write-only words read zero
  always_comb
  begin
    readdata_next = 32'h0000_0000;
    if (word_aligned)
    begin
      case (reg_index)
        comparator_pkg::CONTROL_INDEX:
        begin
          readdata_next[7:0] = control_reg;
          readdata_next[comparator_pkg::CTL_RESULT_BIT] = live_result; // see R4
        end
        comparator_pkg::IRQ_STATUS_INDEX: readdata_next[1:0] = irq_status_reg;
        comparator_pkg::IRQ_MASK_INDEX: readdata_next[1:0] = irq_mask_reg;
        default: readdata_next = 32'h0000_0000;
      endcase
    end
  end

  // read data captured when the request is first seen
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      readdata_reg <= 32'h0000_0000;
    else if (accept && read_i)
      readdata_reg <= readdata_next;
  end

  assign readdata_o = readdata_reg;

  // control register; result bit is not stored
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      control_reg <= comparator_pkg::CONTROL_RESET; // see R3
    else if (write_take && reg_index == comparator_pkg::CONTROL_INDEX)
    begin
      control_reg <= writedata_i[7:0]; // see R1 R2 R3 R5 R6
      control_reg[comparator_pkg::CTL_RESULT_BIT] <= 1'b0;
    end
  end

  // selection register, write-only
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      selection_reg <= comparator_pkg::SELECTION_RESET;
    else if (write_take && reg_index == comparator_pkg::SELECTION_INDEX)
      selection_reg <= writedata_i[7:0]; // see R7 R8 R9 R10
  end

  // interrupt mask
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      irq_mask_reg <= comparator_pkg::IRQ_RESET;
    else if (write_take && reg_index == comparator_pkg::IRQ_MASK_INDEX)
      irq_mask_reg <= writedata_i[1:0];
  end

  // write-one-to-clear strobes
  assign irq_clear = (write_take && reg_index == comparator_pkg::IRQ_STATUS_INDEX) ? writedata_i[1:0] : 2'h0;

  // comparator output crosses in by two flip-flops
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      raw_meta_reg <= 1'b0;
      raw_sync_reg <= 1'b0;
    end
    else
    begin
      raw_meta_reg <= compare_raw_i;
      raw_sync_reg <= raw_meta_reg;
    end
  end

  // timer-two clock sampled as a level, then edge detected
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tm2_meta_reg <= 1'b0;
      tm2_sync_reg <= 1'b0;
      tm2_prev_reg <= 1'b0;
    end
    else
    begin
      tm2_meta_reg <= timer_two_clock_i;
      tm2_sync_reg <= tm2_meta_reg;
      tm2_prev_reg <= tm2_sync_reg;
    end
  end

  assign tm2_rise = tm2_sync_reg & ~tm2_prev_reg; // see R14

  // disabled comparator reports low
  assign live_result = comp_enabled & raw_sync_reg; // see R3 R4

  // analog switch decode
  input_route u_input_route (
    .control_i(control_reg),
    .selection_i(selection_reg),
    .ctl_o(analog_ctl_o)
  );

  // inversion and resampling
  result_shaper u_result_shaper (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .live_i(live_result),
    .invert_i(invert_sel),
    .resample_i(resample_sel),
    .sample_edge_i(tm2_rise),
    .shaped_o(shaped_result)
  );

  // level change detection on the shaped result
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      shaped_prev_reg <= 1'b0;
    else
      shaped_prev_reg <= shaped_result;
  end

  assign result_rise = shaped_result & ~shaped_prev_reg;
  assign result_fall = ~shaped_result & shaped_prev_reg;

  always_comb
  begin
    irq_events = 2'h0;
    irq_events[comparator_pkg::IRQ_RISE_BIT] = result_rise; // see R12 R14
    irq_events[comparator_pkg::IRQ_FALL_BIT] = result_fall; // see R12 R14
  end

  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      irq_status_reg <= comparator_pkg::IRQ_RESET;
    else
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events; // see R12
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg); // see R12

  // wake pulse on any level change while enabled
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      wake_reg <= 1'b0;
    else
      wake_reg <= wake_sel & comp_enabled & (result_rise | result_fall); // see R8 R11
  end

  assign wake_o = wake_reg;

  // pin and timer source follow the shaped result
  assign port_a_pin_zero_o = shaped_result; // see R7 R14
  assign port_a_pin_zero_oe_o = pin_out_sel; // see R7
  assign timer_clock_source_o = shaped_result; // see R13

endmodule : analog_comparator_control

//--- verilog/comparator_pkg.sv
// shared constants and types for the comparator control block
package comparator_pkg;

  // register indexes; byte address is four times the index
  localparam logic [5:0] CONTROL_INDEX = 6'h18;
  localparam logic [5:0] SELECTION_INDEX = 6'h19;
  localparam logic [5:0] IRQ_STATUS_INDEX = 6'h1A;
  localparam logic [5:0] IRQ_MASK_INDEX = 6'h1B;

  // control register fields
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_RESULT_BIT = 6;
  localparam int CTL_RESAMPLE_BIT = 5;
  localparam int CTL_INVERT_BIT = 4;
  localparam int CTL_MINUS_MSB = 3;
  localparam int CTL_MINUS_LSB = 1;
  localparam int CTL_PLUS_BIT = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // selection register fields
  localparam int SEL_PIN_OUT_BIT = 7;
  localparam int SEL_WAKE_BIT = 6;
  localparam int SEL_HIGH_RANGE_BIT = 5;
  localparam int SEL_LOW_RANGE_BIT = 4;
  localparam int SEL_LEVEL_MSB = 3;
  localparam logic [7:0] SELECTION_RESET = 8'h00;

  // interrupt status and mask layout
  localparam int IRQ_RISE_BIT = 0;
  localparam int IRQ_FALL_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // minus input codes
  localparam logic [2:0] MINUS_PIN_A3 = 3'h0;
  localparam logic [2:0] MINUS_PIN_A4 = 3'h1;
  localparam logic [2:0] MINUS_BANDGAP = 3'h2;
  localparam logic [2:0] MINUS_LADDER = 3'h3;
  localparam logic [2:0] MINUS_PIN_B7 = 3'h5;

  // bus answer states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

  // switch controls toward the analog comparator and ladder
  typedef struct packed {
    logic enable;
    logic plus_ladder;
    logic plus_pin_four;
    logic minus_pin_three;
    logic minus_pin_four;
    logic minus_bandgap;
    logic minus_ladder;
    logic minus_pin_seven;
    logic high_range;
    logic low_range;
    logic [3:0] level;
  } analog_ctl_t;

endpackage : comparator_pkg

//--- verilog/input_route.sv
// decodes the input selects into analog switch enables, at most one closed per comparator input
`timescale 1ns/100ps
module input_route (
  input wire logic [7:0] control_i,
  input wire logic [7:0] selection_i,
  output comparator_pkg::analog_ctl_t ctl_o
);

  logic [2:0] minus_code;
  logic enabled;

  assign minus_code = control_i[comparator_pkg::CTL_MINUS_MSB:comparator_pkg::CTL_MINUS_LSB];
  assign enabled = control_i[comparator_pkg::CTL_ENABLE_BIT];

  // plus and minus switches stay open while the comparator is off; ladder range and level pass through
  always_comb
  begin
    ctl_o = '0;
    ctl_o.enable = enabled; // see R3
    ctl_o.plus_ladder = enabled & ~control_i[comparator_pkg::CTL_PLUS_BIT]; // see R1
    ctl_o.plus_pin_four = enabled & control_i[comparator_pkg::CTL_PLUS_BIT]; // see R1
    // reserved codes close no switch
    case (minus_code)
      comparator_pkg::MINUS_PIN_A3: ctl_o.minus_pin_three = enabled; // see R2
      comparator_pkg::MINUS_PIN_A4: ctl_o.minus_pin_four = enabled; // see R2
      comparator_pkg::MINUS_BANDGAP: ctl_o.minus_bandgap = enabled; // see R2
      comparator_pkg::MINUS_LADDER: ctl_o.minus_ladder = enabled; // see R2
      comparator_pkg::MINUS_PIN_B7: ctl_o.minus_pin_seven = enabled; // see R2
      default: ctl_o.minus_pin_three = 1'b0;
    endcase
    ctl_o.high_range = selection_i[comparator_pkg::SEL_HIGH_RANGE_BIT]; // see R9
    ctl_o.low_range = selection_i[comparator_pkg::SEL_LOW_RANGE_BIT]; // see R9
    ctl_o.level = selection_i[comparator_pkg::SEL_LEVEL_MSB:0]; // see R10
  end

endmodule : input_route

//--- verilog/result_shaper.sv
// inverts and optionally resamples the comparator result
`timescale 1ns/100ps
module result_shaper (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic live_i,
  input wire logic invert_i,
  input wire logic resample_i,
  input wire logic sample_edge_i,
  output logic shaped_o
);

  logic inverted;
  logic sample_reg;
  logic shaped_reg;

  // inversion comes before every consumer except the control register result bit
  assign inverted = live_i ^ invert_i; // see R6 R14

  // hold the level seen at each timer-two rising edge
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      sample_reg <= 1'b0;
    else if (sample_edge_i)
      sample_reg <= inverted; // see R5 R14
  end

  // pick resampled or direct result
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      shaped_reg <= 1'b0;
    else
      shaped_reg <= resample_i ? sample_reg : inverted; // see R5
  end

  assign shaped_o = shaped_reg;

endmodule : result_shaper
